//--- src/ctx_op_decode.sv
// per opcode machine cycle count and external move decode
`timescale 1ns/1ps
`default_nettype none
module ctx_op_decode (
  input wire logic [7:0] opcode,
  input wire logic [2:0] stretch,
  output logic [3:0] mc_total,
  output logic is_xmove,
  output logic xmove_write,
  output logic xmove_ptr,
  output logic ri_sel
);

  localparam logic [3:0] CTX_BASE = ctx_pkg::CTX_XMOVE_BASE_CYCLES;

  // external move opcodes: E0/E2/E3 read, F0/F2/F3 write
  always_comb
  begin
    is_xmove = (opcode[7:5] == 3'b111) && (opcode[3:2] == 2'b00) && (opcode[1:0] != 2'b01);
    xmove_write = opcode[4];
    xmove_ptr = (opcode[1:0] == 2'b00);
    ri_sel = opcode[0];
  end

  // cycle class per opcode, not derived from length alone
  always_comb
  begin
    if (opcode[3])
      mc_total = 4'h1; // register forms, 128 opcodes
    else if (is_xmove)
      mc_total = CTX_BASE + {1'b0, stretch};
    else
    begin
      case (opcode)
        8'h22, 8'h32, 8'h83, 8'h93, 8'hA3: mc_total = 4'h2;
        8'h12: mc_total = 4'h4;
        8'h84, 8'hA4: mc_total = 4'h5;
        8'h90: mc_total = 4'h3;
        default: mc_total = (opcode[1:0] == 2'b11) ? 4'h3 : 4'h2;
      endcase
    end
  end

endmodule : ctx_op_decode
`default_nettype wire

//--- src/ctx_phase_gen.sv
// four state machine cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module ctx_phase_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  ctx_seq_if.gen seq
);

  ctx_pkg::ctx_clk_state_e state_reg;
  ctx_pkg::ctx_clk_state_e state_next;

  // step through the four states, wrapping after the fourth
  always_comb
  begin
    case (state_reg)
      ctx_pkg::CTX_FIRST: state_next = ctx_pkg::CTX_SECOND;
      ctx_pkg::CTX_SECOND: state_next = ctx_pkg::CTX_THIRD;
      ctx_pkg::CTX_THIRD: state_next = ctx_pkg::CTX_FOURTH;
      default: state_next = ctx_pkg::CTX_FIRST;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= ctx_pkg::CTX_FIRST;
    else
      state_reg <= state_next;
  end

  assign seq.clk_state = state_reg;
  assign seq.cycle_last = (state_reg == ctx_pkg::CTX_FOURTH);

endmodule : ctx_phase_gen
`default_nettype wire

//--- src/ctx_pkg.sv
// constants, types and decode helpers for the cycle timing and external move block
//
// Function
// - machine cycle is four clock states, first to fourth
// - both clock edges time internal operations
// - one opcode byte fetched per machine cycle
// - exactly half of all opcodes single cycle
// - some one-byte opcodes take two cycles
// - other instructions take three, four or five cycles
// - external move lasts two to nine cycles
// - strobe lengthens with the stretch value
// - external move reads or writes external data space
// - indirect form low byte from work register
// - indirect form high byte from port two
// - pointer form address from selected pointer
// - two pointers, select bit zero at 86h
// - other select register bits read zero
// - select zero primary, one secondary pointer
// - increment on select register toggles pointer
// - opcode fetch cycle, then address and access
// - stretch field gives 2..9 cycles, default one
// - stretch affects only the external move
package ctx_pkg;

  // ************************************************************
  // clock states and timing
  // ************************************************************
  typedef enum logic [1:0] {CTX_FIRST, CTX_SECOND, CTX_THIRD, CTX_FOURTH} ctx_clk_state_e;
  localparam int CTX_STATES_PER_CYCLE = 4;
  localparam logic [3:0] CTX_XMOVE_BASE_CYCLES = 4'h2;
  localparam logic [4:0] CTX_STRETCH0_STROBE = 5'h02;
  localparam logic [2:0] CTX_STRETCH_RST = 3'h1;

  // ************************************************************
  // register indexes (byte address is four times the index)
  // ************************************************************
  localparam int CTX_AW = 12;
  localparam logic [9:0] CTX_IDX_DPS = 10'h086;
  localparam logic [9:0] CTX_IDX_CLKCTL = 10'h0C0;
  localparam logic [9:0] CTX_IDX_DP0 = 10'h0C1;
  localparam logic [9:0] CTX_IDX_DP1 = 10'h0C2;
  localparam logic [9:0] CTX_IDX_PORT2 = 10'h0C3;
  localparam logic [9:0] CTX_IDX_WREG = 10'h0C4;
  localparam logic [9:0] CTX_IDX_ACC = 10'h0C5;
  localparam logic [9:0] CTX_IDX_CMD = 10'h0C6;
  localparam logic [9:0] CTX_IDX_STATUS = 10'h0C7;
  localparam logic [7:0] CTX_DPS_RST = 8'h00;
  localparam logic [7:0] CTX_DPS_SFR_ADDR = 8'h86;

  // ************************************************************
  // opcodes that the block acts on
  // ************************************************************
  localparam logic [7:0] CTX_OP_INC_DIR = 8'h05;
  localparam logic [7:0] CTX_OP_DEC_DIR = 8'h15;
  localparam logic [7:0] CTX_OP_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] CTX_OP_MOV_PTR_IMM = 8'h90;
  localparam logic [7:0] CTX_OP_INC_PTR = 8'hA3;

  // word index of an aligned byte address
  function automatic logic [9:0] ctx_reg_idx(input logic [CTX_AW-1:0] addr);
    ctx_reg_idx = addr[CTX_AW-1:2];
  endfunction : ctx_reg_idx

  // strobe width in clocks for a stretch value
  function automatic logic [4:0] ctx_strobe_width(input logic [2:0] stretch);
    ctx_strobe_width = (stretch == 3'h0) ? CTX_STRETCH0_STROBE : {stretch, 2'b00};
  endfunction : ctx_strobe_width

endpackage : ctx_pkg

//--- src/ctx_seq_if.sv
// clock state sequence shared between the phase generator and the core
`timescale 1ns/1ps
`default_nettype none
interface ctx_seq_if;
  ctx_pkg::ctx_clk_state_e clk_state;
  logic cycle_last;
  modport gen (output clk_state, output cycle_last);
  modport core (input clk_state, input cycle_last);
endinterface : ctx_seq_if
`default_nettype wire

//--- src/ctx_top.sv
// instruction cycle timing and external data move addressing with apb registers
`timescale 1ns/1ps
`default_nettype none
module ctx_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctx_pkg::CTX_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] ext_addr,
  input wire logic [7:0] ext_data_in,
  output logic [7:0] ext_data_out,
  output logic ext_data_oe,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic [1:0] clock_state,
  output logic busy
);

  // ************************************************************
  // sequencer and decoder
  // ************************************************************
  ctx_seq_if seq ();

  ctx_phase_gen u_phase (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .seq(seq)
  );

  typedef enum logic [1:0] {CTX_IDLE, CTX_ARM, CTX_RUN} ctx_exec_e;

  ctx_exec_e st_reg, st_next;
  logic [7:0] op_reg, op_next;
  logic [15:0] operand_reg, operand_next;
  logic [3:0] mc_left_reg, mc_left_next;
  logic [3:0] mc_idx_reg, mc_idx_next;
  logic [4:0] strobe_reg, strobe_next;
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, oe_reg, oe_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic retire;
  logic [3:0] mc_total;
  logic is_xmove, xmove_write, xmove_ptr, ri_sel;

  // register file state
  logic [2:0] stretch_reg, stretch_next;
  logic dps_reg, dps_next;
  logic [15:0] dp0_reg, dp0_next, dp1_reg, dp1_next;
  logic [7:0] port2_reg, port2_next, acc_reg, acc_next;
  logic [1:0] bank_reg, bank_next;
  logic [7:0] wreg_mem [0:7];
  logic [7:0] wreg_next [0:7];

  ctx_op_decode u_decode (
    .opcode(op_reg),
    .stretch(stretch_reg),
    .mc_total(mc_total),
    .is_xmove(is_xmove),
    .xmove_write(xmove_write),
    .xmove_ptr(xmove_ptr),
    .ri_sel(ri_sel)
  );

  // ************************************************************
  // apb decode
  // ************************************************************
  logic [9:0] idx;
  logic acc_phase, wr_en, known, cmd_refused;
  logic [15:0] sel_ptr;

  always_comb
  begin
    idx = ctx_pkg::ctx_reg_idx(paddr);
    acc_phase = psel && penable;
    case (idx)
      ctx_pkg::CTX_IDX_DPS, ctx_pkg::CTX_IDX_CLKCTL, ctx_pkg::CTX_IDX_DP0,
      ctx_pkg::CTX_IDX_DP1, ctx_pkg::CTX_IDX_PORT2, ctx_pkg::CTX_IDX_WREG,
      ctx_pkg::CTX_IDX_ACC, ctx_pkg::CTX_IDX_CMD, ctx_pkg::CTX_IDX_STATUS: known = 1'b1;
      default: known = 1'b0;
    endcase
    cmd_refused = pwrite && (idx == ctx_pkg::CTX_IDX_CMD) && (st_reg != CTX_IDLE);
    wr_en = acc_phase && pwrite && known && !cmd_refused;
    sel_ptr = dps_reg ? dp1_reg : dp0_reg;
  end

  assign pready = 1'b1;
  assign pslverr = acc_phase && (!known || cmd_refused);

  // read data mux, unused bits read zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (acc_phase && !pwrite)
    begin
      case (idx)
        ctx_pkg::CTX_IDX_DPS: prdata = {31'h0000_0000, dps_reg};
        ctx_pkg::CTX_IDX_CLKCTL: prdata = {29'h0000_0000, stretch_reg};
        ctx_pkg::CTX_IDX_DP0: prdata = {16'h0000, dp0_reg};
        ctx_pkg::CTX_IDX_DP1: prdata = {16'h0000, dp1_reg};
        ctx_pkg::CTX_IDX_PORT2: prdata = {24'h00_0000, port2_reg};
        ctx_pkg::CTX_IDX_WREG: prdata = {14'h0000, bank_reg,
                                         wreg_mem[{bank_reg, 1'b1}], wreg_mem[{bank_reg, 1'b0}]};
        ctx_pkg::CTX_IDX_ACC: prdata = {24'h00_0000, acc_reg};
        ctx_pkg::CTX_IDX_CMD: prdata = {8'h00, operand_reg, op_reg};
        ctx_pkg::CTX_IDX_STATUS: prdata = {20'h0_0000, mc_idx_reg, mc_left_reg,
                                           !rd_n_reg || !wr_n_reg, busy, seq.clk_state};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // execution sequencing
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    operand_next = operand_reg;
    mc_left_next = mc_left_reg;
    mc_idx_next = mc_idx_reg;
    strobe_next = (strobe_reg != 5'h00) ? strobe_reg - 5'h01 : 5'h00;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    oe_next = oe_reg;
    retire = 1'b0;
    case (st_reg)
      CTX_IDLE:
      begin
        if (wr_en && (idx == ctx_pkg::CTX_IDX_CMD))
        begin
          op_next = pwdata[7:0];
          operand_next = pwdata[23:8];
          st_next = CTX_ARM;
        end
      end
      CTX_ARM:
      begin
        // instructions start on a machine cycle boundary
        if (seq.cycle_last)
        begin
          st_next = CTX_RUN;
          mc_left_next = mc_total;
          mc_idx_next = 4'h0;
        end
      end
      CTX_RUN:
      begin
        // address for the access cycle after the fetch cycle
        if (is_xmove && seq.cycle_last && (mc_idx_reg == 4'h0))
        begin
          addr_next = xmove_ptr ? sel_ptr
                                : {port2_reg, wreg_mem[{bank_reg, ri_sel}]};
          wdata_next = acc_reg;
          oe_next = xmove_write;
        end
        // strobe starts in the second state of the access cycle
        if (is_xmove && (mc_idx_reg == 4'h1) && (seq.clk_state == ctx_pkg::CTX_FIRST))
          strobe_next = ctx_pkg::ctx_strobe_width(stretch_reg);
        if (seq.cycle_last)
        begin
          mc_idx_next = mc_idx_reg + 4'h1;
          mc_left_next = mc_left_reg - 4'h1;
          if (mc_left_reg == 4'h1)
          begin
            retire = 1'b1;
            oe_next = 1'b0;
            st_next = CTX_IDLE;
          end
        end
      end
      default: st_next = CTX_IDLE;
    endcase
    rd_n_next = !((strobe_next != 5'h00) && !xmove_write);
    wr_n_next = !((strobe_next != 5'h00) && xmove_write);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= CTX_IDLE;
      op_reg <= 8'h00;
      operand_reg <= 16'h0000;
      mc_left_reg <= 4'h0;
      mc_idx_reg <= 4'h0;
      strobe_reg <= 5'h00;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      operand_reg <= operand_next;
      mc_left_reg <= mc_left_next;
      mc_idx_reg <= mc_idx_next;
      strobe_reg <= strobe_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      oe_reg <= oe_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // ************************************************************
  // read data path: pin sync, falling edge capture
  // ************************************************************
  logic [7:0] din_meta_reg, din_sync_reg, din_fall_reg;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end
    else
    begin
      din_meta_reg <= ext_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // sample mid way through the last strobe clock
  always_ff @(negedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      din_fall_reg <= 8'h00;
    else if ((strobe_reg == 5'h01) && !xmove_write)
      din_fall_reg <= din_sync_reg;
  end

  // ************************************************************
  // register file and instruction effects
  // ************************************************************
  always_comb
  begin
    stretch_next = stretch_reg;
    dps_next = dps_reg;
    dp0_next = dp0_reg;
    dp1_next = dp1_reg;
    port2_next = port2_reg;
    acc_next = acc_reg;
    bank_next = bank_reg;
    for (int i = 0; i < 8; i++)
      wreg_next[i] = wreg_mem[i];
    if (wr_en)
    begin
      case (idx)
        ctx_pkg::CTX_IDX_DPS: dps_next = pwdata[0];
        ctx_pkg::CTX_IDX_CLKCTL: stretch_next = pwdata[2:0];
        ctx_pkg::CTX_IDX_DP0: dp0_next = pwdata[15:0];
        ctx_pkg::CTX_IDX_DP1: dp1_next = pwdata[15:0];
        ctx_pkg::CTX_IDX_PORT2: port2_next = pwdata[7:0];
        ctx_pkg::CTX_IDX_ACC: acc_next = pwdata[7:0];
        ctx_pkg::CTX_IDX_WREG:
        begin
          bank_next = pwdata[17:16];
          wreg_next[{pwdata[17:16], 1'b0}] = pwdata[7:0];
          wreg_next[{pwdata[17:16], 1'b1}] = pwdata[15:8];
        end
        default: acc_next = acc_reg;
      endcase
    end
    // read data lands when the strobe ends
    if ((strobe_reg == 5'h01) && !xmove_write)
      acc_next = din_fall_reg;
    // instruction results win over a same cycle bus write
    if (retire)
    begin
      case (op_reg)
        ctx_pkg::CTX_OP_INC_DIR, ctx_pkg::CTX_OP_DEC_DIR:
          if (operand_reg[7:0] == ctx_pkg::CTX_DPS_SFR_ADDR)
            dps_next = !dps_reg;
        ctx_pkg::CTX_OP_MOV_DIR_IMM:
          if (operand_reg[7:0] == ctx_pkg::CTX_DPS_SFR_ADDR)
            dps_next = operand_reg[8];
        ctx_pkg::CTX_OP_MOV_PTR_IMM:
          if (dps_reg)
            dp1_next = {operand_reg[7:0], operand_reg[15:8]};
          else
            dp0_next = {operand_reg[7:0], operand_reg[15:8]};
        ctx_pkg::CTX_OP_INC_PTR:
          if (dps_reg)
            dp1_next = dp1_reg + 16'h0001;
          else
            dp0_next = dp0_reg + 16'h0001;
        default: dps_next = dps_next;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stretch_reg <= ctx_pkg::CTX_STRETCH_RST;
      dps_reg <= ctx_pkg::CTX_DPS_RST[0];
      dp0_reg <= 16'h0000;
      dp1_reg <= 16'h0000;
      port2_reg <= 8'hFF;
      acc_reg <= 8'h00;
      bank_reg <= 2'h0;
      for (int i = 0; i < 8; i++)
        wreg_mem[i] <= 8'h00;
    end
    else
    begin
      stretch_reg <= stretch_next;
      dps_reg <= dps_next;
      dp0_reg <= dp0_next;
      dp1_reg <= dp1_next;
      port2_reg <= port2_next;
      acc_reg <= acc_next;
      bank_reg <= bank_next;
      for (int i = 0; i < 8; i++)
        wreg_mem[i] <= wreg_next[i];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign ext_addr = addr_reg;
  assign ext_data_out = wdata_reg;
  assign ext_data_oe = oe_reg;
  assign ext_rd_n = rd_n_reg;
  assign ext_wr_n = wr_n_reg;
  assign clock_state = seq.clk_state;
  assign busy = (st_reg != CTX_IDLE);

endmodule : ctx_top
`default_nettype wire

//--- verification/ctx_ext_mem.sv
// external data memory model with adjustable access time
`timescale 1ns/1ps
`default_nettype none
module ctx_ext_mem (
  input wire logic sys_clk,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic ext_wr_n,
  input wire logic [3:0] lag,
  output logic [7:0] ext_data_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_reg = 16'h0000;
  logic [3:0] age_reg = 4'h0;
  logic [7:0] junk_reg = 8'h3C;
  // never written locations hold a fixed pattern
  initial
  begin
    for (int a = 0; a < 65536; a++)
      mem[a] = a[15:8] ^ a[7:0] ^ 8'h5A;
  end
  // location content
  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem[a];
  endfunction : peek
  // store writes, age the address, keep the idle bus moving
  always @(posedge sys_clk)
  begin
    if (!ext_wr_n && ext_data_oe)
      mem[ext_addr] = ext_data_out;
    age_reg <= (ext_addr == addr_reg && age_reg != 4'hF) ? age_reg + 4'h1 : 4'h0;
    addr_reg <= ext_addr;
    junk_reg <= ~junk_reg + 8'h01;
  end
  // data valid only once the address has settled for the access time
  always_comb ext_data_in = (!ext_data_oe && age_reg >= lag) ? peek(ext_addr) : junk_reg;
endmodule : ctx_ext_mem
`default_nettype wire

//--- verification/ctx_top_chk.sv
// assertion checker for the cycle timing block
`timescale 1ns/1ps
`default_nettype none
module ctx_top_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [1:0] clock_state,
  input wire logic busy
);
  // ******
  // assertions
  // ******
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // states, instruction length and strobe timing
  property p_state_step;
    $past(resetn) |-> clock_state == $past(clock_state) + 2'h1;
  endproperty
  a_state_step: assert property (p_state_step) else $error("state skipped");
  property p_busy_min;
    $rose(busy) |-> busy[*4];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_max;
    $rose(busy) |-> ##[4:44] !busy;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_end;
    $fell(busy) |-> clock_state == 2'h0;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("retired mid cycle");
  property p_strobe_start;
    $fell(ext_rd_n) || $fell(ext_wr_n) |-> clock_state == 2'h1;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("strobe state");
  property p_rd_width;
    $fell(ext_rd_n) |-> (!ext_rd_n)[*2] ##[1:27] ext_rd_n;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe width");
  property p_wr_width;
    $fell(ext_wr_n) |-> (!ext_wr_n)[*2] ##[1:27] ext_wr_n;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe width");
  property p_addr_hold;
    (!ext_rd_n && !$fell(ext_rd_n)) || (!ext_wr_n && !$fell(ext_wr_n)) |-> $stable(ext_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_wr_drive;
    !ext_wr_n |-> ext_data_oe && $stable(ext_data_out);
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data");
  property p_idle_quiet;
    !busy |-> ext_rd_n && ext_wr_n && !ext_data_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle strobe");
endmodule : ctx_top_chk

bind ctx_top ctx_top_chk ctx_top_chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
  .ext_data_oe(ext_data_oe), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
  .clock_state(clock_state), .busy(busy)
);
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the cycle timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic ext_data_oe, ext_rd_n, ext_wr_n, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] ext_addr, dp0, dp1;
  logic [7:0] ext_data_in, ext_data_out, p2, r0, r1, acc, b1, b2;
  logic [3:0] lag;
  logic [2:0] s;
  logic [1:0] clock_state;
  int err_count, comparisons, cyc, seed, w_cnt, last_w, singles, d, m;

  ctx_top ctx_top_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_addr(ext_addr), .ext_data_in(ext_data_in),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .clock_state(clock_state), .busy(busy));
  ctx_ext_mem ctx_ext_mem_i (.sys_clk(sys_clk), .ext_addr(ext_addr),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_wr_n(ext_wr_n),
    .lag(lag), .ext_data_in(ext_data_in));

  // ******
  // clock, timeout and strobe width
  // ******
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // cycle count with a ceiling
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  // width of the last strobe in clocks
  always @(negedge sys_clk)
  begin
    if (!ext_rd_n || !ext_wr_n)
      w_cnt <= w_cnt + 1;
    else if (w_cnt != 0)
    begin
      last_w <= w_cnt;
      w_cnt <= 0;
    end
  end

  // ******
  // expectations and bus tasks
  // ******
  function automatic int exp_mc(input logic [7:0] op, input logic [2:0] st);
    if (op[3])
      return 1;
    case (op)
      8'h22, 8'h32, 8'h83, 8'h93, 8'hA3: return 2;
      8'h12: return 4;
      8'h84, 8'hA4: return 5;
      8'h90: return 3;
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: return 2 + st;
      default: return (op[1:0] == 2'h3) ? 3 : 2;
    endcase
  endfunction : exp_mc
  function automatic int exp_w(input logic [2:0] st);
    return (st == 3'h0) ? 2 : 4 * st;
  endfunction : exp_w
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] dat);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  // set stretch, issue an instruction, measure its machine cycles into m
  task automatic run(input logic [7:0] op, input logic [2:0] st);
    apb(1'b1, ctx_pkg::CTX_IDX_CLKCTL, {29'h0, st});
    apb(1'b1, ctx_pkg::CTX_IDX_CMD, {8'h00, b2, b1, op});
    d = 0;
    while (busy === 1'b1)
    begin
      d++;
      @(posedge sys_clk);
    end
    // busy spans one to four waiting clocks plus four per machine cycle
    m = (d - 1) / 4;
  endtask : run
  task automatic print_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ******
  // main sequence
  // ******
  initial
  begin
    {seed, err_count, comparisons, cyc, w_cnt, last_w, singles} = {32'd76045, 192'h0};
    {resetn, psel, penable, pwrite, paddr, pwdata, lag, b1, b2} = 68'h0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, ctx_pkg::CTX_IDX_DPS, 32'h0);
    chk(q, 32'h0, "select reset");
    apb(1'b0, ctx_pkg::CTX_IDX_CLKCTL, 32'h0);
    chk(q[2:0], 3'h1, "stretch reset");
    apb(1'b1, ctx_pkg::CTX_IDX_DPS, 32'hFF);
    apb(1'b0, ctx_pkg::CTX_IDX_DPS, 32'h0);
    chk(q, 32'h1, "select upper bits");
    apb(1'b0, 10'h001, 32'h0);
    chk(e, 1'b1, "unmapped");
    // indirect form writes then a read
    p2 = 8'($random(seed));
    {r1, r0, acc} = 24'($random(seed));
    apb(1'b1, ctx_pkg::CTX_IDX_PORT2, {24'h0, p2});
    apb(1'b1, ctx_pkg::CTX_IDX_WREG, {14'h0, 2'($random(seed)), r1, r0});
    apb(1'b1, ctx_pkg::CTX_IDX_ACC, {24'h0, acc});
    run(8'hF2, 3'h0);
    chk(ctx_ext_mem_i.peek({p2, r0}), acc, "write r0");
    chk(last_w, exp_w(3'h0), "width");
    run(8'hF3, 3'h1);
    chk(ctx_ext_mem_i.peek({p2, r1}), acc, "write r1");
    chk(last_w, exp_w(3'h1), "width");
    r0 = ~r0;
    apb(1'b1, ctx_pkg::CTX_IDX_WREG, {16'h0, r1, r0});
    run(8'hE2, 3'h3);
    apb(1'b0, ctx_pkg::CTX_IDX_ACC, 32'h0);
    chk(q[7:0], ctx_ext_mem_i.peek({p2, r0}), "read r0");
    chk(last_w, exp_w(3'h3), "width");
    // pointer form through each pointer
    {dp1, dp0} = $random(seed);
    apb(1'b1, ctx_pkg::CTX_IDX_DP0, {16'h0, dp0});
    apb(1'b1, ctx_pkg::CTX_IDX_DP1, {16'h0, dp1});
    for (int k = 0; k < 2; k++)
    begin
      acc = 8'($random(seed));
      apb(1'b1, ctx_pkg::CTX_IDX_DPS, 32'(k));
      apb(1'b1, ctx_pkg::CTX_IDX_ACC, {24'h0, acc});
      run(8'hF0, 3'h2);
      chk(ctx_ext_mem_i.peek(k ? dp1 : dp0), acc, "pointer write");
    end
    // select bit changed by instructions: inc, dec, move 0, move 1
    b1 = 8'h86;
    for (int k = 0; k < 4; k++)
    begin
      b2 = (k == 2) ? 8'hFE : 8'h01;
      run((k < 2) ? ((k == 0) ? 8'h05 : 8'h15) : 8'h75, 3'h1);
      apb(1'b0, ctx_pkg::CTX_IDX_DPS, 32'h0);
      chk(q, 32'(k % 2), "select");
    end
    {b1, b2} = 16'($random(seed));
    run(8'h90, 3'h1);
    apb(1'b0, ctx_pkg::CTX_IDX_DP1, 32'h0);
    chk(q[15:0], {b1, b2}, "pointer load");
    apb(1'b0, ctx_pkg::CTX_IDX_DP0, 32'h0);
    chk(q[15:0], dp0, "other pointer");
    run(8'hA3, 3'h1);
    dp1 = {b1, b2} + 16'h0001;
    apb(1'b0, ctx_pkg::CTX_IDX_DP1, 32'h0);
    chk(q[15:0], dp1, "pointer inc");
    // slow memory with the longest stretch
    lag <= 4'h6;
    run(8'hE0, 3'h7);
    apb(1'b0, ctx_pkg::CTX_IDX_ACC, 32'h0);
    chk(q[7:0], ctx_ext_mem_i.peek(dp1), "slow read");
    chk(last_w, exp_w(3'h7), "width");
    lag <= 4'h0;
    // command refused while busy
    apb(1'b1, ctx_pkg::CTX_IDX_CMD, 32'h12);
    apb(1'b1, ctx_pkg::CTX_IDX_CMD, 32'hA3);
    chk(e, 1'b1, "busy refusal");
    while (busy !== 1'b0)
      @(negedge sys_clk);
    @(posedge sys_clk);
    apb(1'b0, ctx_pkg::CTX_IDX_DP1, 32'h0);
    chk(q[15:0], dp1, "refused ignored");
    apb(1'b0, ctx_pkg::CTX_IDX_STATUS, 32'h0);
    chk(q[11:2], {4'h4, 4'h0, 2'h0}, "status idle");
    // reset while idle returns select and stretch to their defaults
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, ctx_pkg::CTX_IDX_DPS, 32'h0);
    chk(q, 32'h0, "select after reset");
    apb(1'b0, ctx_pkg::CTX_IDX_CLKCTL, 32'h0);
    chk(q, 32'h1, "stretch after reset");
    // every opcode with random stretch and operands
    for (int op = 0; op < 256; op++)
    begin
      s = 3'($random(seed));
      {b1, b2} = 16'($random(seed));
      run(8'(op), s);
      chk(m, exp_mc(8'(op), s), "cycles");
      singles += (m == 1);
    end
    chk(singles, 128, "single cycle count");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
